// >>> rtl/logic_rule_dispatch.sv
// logic rule evaluator and action dispatcher of the drive logic function
// assumes conditions and enable pin are asynchronous and are synchronised
// here; action outputs go to the motion and speed control core
`timescale 1ns/1ps

module logic_rule_dispatch (
  input  wire logic                                 CLK,
  input  wire logic                                 NRST,
  input  wire logic [7:0]                           ADDR,
  input  wire logic [31:0]                          WDATA,
  input  wire logic                                 WR,
  input  wire logic                                 RD,
  output logic      [31:0]                          RDATA,
  input  wire logic [logic_rule_pkg::NUM_CONDS-1:0] COND_IN,
  input  wire logic                                 HW_ENABLE_IN,
  input  wire logic [logic_rule_pkg::SPEED_W-1:0]   SPEED_CMD_IN,
  output logic                                      DOUT1,
  output logic                                      DOUT2,
  output logic                                      RELAY1,
  output logic                                      DRIVE_EN,
  output logic                                      JOG_FWD,
  output logic                                      JOG_REV,
  output logic                                      STOP_REQ,
  output logic                                      LOGIC_FAULT,
  output logic                                      FWD_EN,
  output logic                                      REV_EN,
  output logic                                      ACC_GROUP2,
  output logic                                      RESET_REQ,
  output logic                                      PRESET_ACTIVE,
  output logic      [logic_rule_pkg::SPEED_W-1:0]   SPEED_REF
);
  import logic_rule_pkg::*;

  // =====================================================================
  // input synchronisers, two flops before any logic reads a condition or the enable pin
  logic [NUM_CONDS-1:0] cond_s1_r;
  logic [NUM_CONDS-1:0] cond_s2_r;
  logic                 hwen_s1_r;
  logic                 hwen_s2_r;

  always_ff @(posedge CLK) begin
    cond_s1_r <= COND_IN;
    cond_s2_r <= cond_s1_r;
    hwen_s1_r <= HW_ENABLE_IN;
    hwen_s2_r <= hwen_s1_r;
  end

  // =====================================================================
  // register file
  logic [31:0]        ctrl_r;
  logic [31:0]        rule_r   [NUM_RULES];
  logic [SPEED_W-1:0] preset_r [PRESETS];
  logic [SPEED_W-1:0] jog_speed_r;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;
  logic [NUM_VARS-1:0] var_r;
  logic [31:0]        status_w;

  wire wr_ctrl = WR && (ADDR == OFS_CTRL);
  wire wr_jog  = WR && (ADDR == OFS_JOG);

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ctrl_r      <= CTRL_RST;
      jog_speed_r <= SPEED_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= WDATA;
      end
      if (wr_jog) begin
        jog_speed_r <= WDATA[SPEED_W-1:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_RULES; gi++) begin : g_rule_reg
      always_ff @(posedge CLK) begin
        if (!NRST) begin
          rule_r[gi] <= RULE_RST;
        end else if (WR && (ADDR == OFS_RULE0 + 8'(gi))) begin
          rule_r[gi] <= WDATA;
        end
      end
    end
    for (gi = 0; gi < PRESETS; gi++) begin : g_preset_reg
      always_ff @(posedge CLK) begin
        if (!NRST) begin
          preset_r[gi] <= SPEED_RST;
        end else if (WR && (ADDR == OFS_PRESET0 + 8'(gi))) begin
          preset_r[gi] <= WDATA[SPEED_W-1:0];
        end
      end
    end
  endgenerate

  // =====================================================================
  // rule evaluation, fixed order, every cycle while run is set
  logic [NUM_RULES-1:0] res_w;
  logic [NUM_RULES-1:0] valid_w;
  logic [6*NUM_RULES-1:0] act_p;

  generate
    for (gi = 0; gi < NUM_RULES; gi++) begin : g_eval
      wire [NUM_CONDS-1:0] mask = rule_r[gi][NUM_CONDS-1:0];
      wire [NUM_CONDS-1:0] sel  = cond_s2_r & mask;
      wire [2:0] op  = rule_r[gi][RULE_OP_LSB +: 3];
      wire any_c = |sel;
      wire all_c = (sel == mask);
      wire par_c = ^sel;
      // an empty mask makes and true and or false
      assign act_p[gi*6 +: 6] = rule_r[gi][RULE_ACT_LSB +: 6];
      // reserved operator leaves the rule inert
      assign valid_w[gi] = ctrl_r[CTRL_RUN] && (op <= 3'(OP_NAND));
      assign res_w[gi] = (op == 3'(OP_OR))   ? any_c  :
                         (op == 3'(OP_AND))  ? all_c  :
                         (op == 3'(OP_XOR))  ? par_c  :
                         (op == 3'(OP_NOR))  ? !any_c :
                         (op == 3'(OP_NAND)) ? !all_c : 1'b0;
    end
  endgenerate

  // per action: is it programmed, and the result of the last rule on it
  // reserved codes match nothing below and so do nothing
  // rule state goes in as arguments so each wire follows every change
  function automatic logic [1:0] act_of(
    input logic [5:0]             code,
    input logic [NUM_RULES-1:0]   v,
    input logic [NUM_RULES-1:0]   res,
    input logic [6*NUM_RULES-1:0] act
  );
    logic [1:0] r;
    r = 2'b00;
    for (int i = 0; i < NUM_RULES; i++) begin
      if (v[i] && act[i*6 +: 6] == code) begin
        r = {1'b1, res[i]};
      end
    end
    return r;
  endfunction

  wire [1:0] a_d1   = act_of(ACT_DOUT1, valid_w, res_w, act_p);
  wire [1:0] a_d2   = act_of(ACT_DOUT2, valid_w, res_w, act_p);
  wire [1:0] a_r1   = act_of(ACT_RELAY1, valid_w, res_w, act_p);
  wire [1:0] a_en   = act_of(ACT_DRV_EN, valid_w, res_w, act_p);
  wire [1:0] a_jr   = act_of(ACT_JOG_REV, valid_w, res_w, act_p);
  wire [1:0] a_jf   = act_of(ACT_JOG_FWD, valid_w, res_w, act_p);
  wire [1:0] a_st   = act_of(ACT_STOP, valid_w, res_w, act_p);
  wire [1:0] a_je   = act_of(ACT_JOG_EN, valid_w, res_w, act_p);
  wire [1:0] a_ft   = act_of(ACT_FAULT, valid_w, res_w, act_p);
  wire [1:0] a_fe   = act_of(ACT_FWD_EN, valid_w, res_w, act_p);
  wire [1:0] a_re   = act_of(ACT_REV_EN, valid_w, res_w, act_p);
  wire [1:0] a_ag   = act_of(ACT_ACC_GRP, valid_w, res_w, act_p);
  wire [1:0] a_rs   = act_of(ACT_RESET, valid_w, res_w, act_p);
  wire [1:0] a_ps   = act_of(ACT_PRESET, valid_w, res_w, act_p);
  wire [1:0] a_i0   = act_of(ACT_IDX0, valid_w, res_w, act_p);

  logic [NUM_VARS-1:0] var_nxt;
  generate
    for (gi = 0; gi < NUM_VARS; gi++) begin : g_var
      wire [1:0] a_v = act_of(ACT_VAR_BASE + 6'(gi), valid_w, res_w, act_p);
      assign var_nxt[gi] = a_v[1] & a_v[0];
    end
  endgenerate

  // =====================================================================
  // action decode
  wire jog_ok    = a_je[1] & a_je[0];
  // both requests while jogging is allowed turn into a stop
  wire jog_both  = a_jf[0] & a_jr[0] & a_jf[1] & a_jr[1];
  wire jf_nxt    = jog_ok & a_jf[1] & a_jf[0] & !jog_both;
  wire jr_nxt    = jog_ok & a_jr[1] & a_jr[0] & !jog_both;
  wire stop_nxt  = (a_st[1] & a_st[0]) | (jog_ok & jog_both);
  // hardware enable is always needed; an absent action leaves it alone
  wire en_nxt    = hwen_s2_r & (!a_en[1] | a_en[0]);
  wire idx0      = a_i0[1] & a_i0[0];
  wire pre_nxt   = a_ps[1] & a_ps[0];
  // a jog runs at jog speed whatever the speed source
  // only bit 0 exists; index 0 takes the first entry
  wire [SPEED_W-1:0] spd_nxt = (jf_nxt | jr_nxt) ? jog_speed_r :
                               !pre_nxt ? SPEED_CMD_IN :
                               preset_r[idx0];
  // edge detect: a held result issues one reset only
  wire rst_lvl   = a_rs[1] & a_rs[0];
  logic rst_lvl_r;

  // =====================================================================
  // simple level actions
  wire d1_nxt    = ctrl_r[CTRL_SRC1] & a_d1[1] & a_d1[0];
  wire d2_nxt    = ctrl_r[CTRL_SRC2] & a_d2[1] & a_d2[0];
  wire r1_nxt    = ctrl_r[CTRL_SRCR] & a_r1[1] & a_r1[0];
  wire ft_nxt    = a_ft[1] & a_ft[0];
  wire fe_nxt    = a_fe[1] & a_fe[0];
  wire re_nxt    = a_re[1] & a_re[0];
  wire ag_nxt    = a_ag[1] & a_ag[0];

  // =====================================================================
  // action outputs
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      DOUT1         <= 1'b0;
      DOUT2         <= 1'b0;
      RELAY1        <= 1'b0;
      DRIVE_EN      <= 1'b0;
      JOG_FWD       <= 1'b0;
      JOG_REV       <= 1'b0;
      STOP_REQ      <= 1'b0;
      LOGIC_FAULT   <= 1'b0;
      FWD_EN        <= 1'b0;
      REV_EN        <= 1'b0;
      ACC_GROUP2    <= 1'b0;
      RESET_REQ     <= 1'b0;
      PRESET_ACTIVE <= 1'b0;
      SPEED_REF     <= SPEED_RST;
      rst_lvl_r     <= 1'b0;
      var_r         <= '0;
    end else begin
      DOUT1         <= d1_nxt;
      DOUT2         <= d2_nxt;
      RELAY1        <= r1_nxt;
      DRIVE_EN      <= en_nxt;
      JOG_FWD       <= jf_nxt;
      JOG_REV       <= jr_nxt;
      STOP_REQ      <= stop_nxt;
      LOGIC_FAULT   <= ft_nxt;
      FWD_EN        <= fe_nxt;
      REV_EN        <= re_nxt;
      ACC_GROUP2    <= ag_nxt;
      RESET_REQ     <= rst_lvl & !rst_lvl_r;
      PRESET_ACTIVE <= pre_nxt;
      SPEED_REF     <= spd_nxt;
      rst_lvl_r     <= rst_lvl;
      var_r         <= var_nxt;
    end
  end

  // =====================================================================
  // read port
  assign status_w = {14'h0000, LOGIC_FAULT, STOP_REQ, JOG_REV, JOG_FWD,
                     DRIVE_EN, ACC_GROUP2, PRESET_ACTIVE, REV_EN, FWD_EN,
                     RELAY1, DOUT2, DOUT1, 4'h0, idx0, hwen_s2_r};

  wire       in_rule    = (ADDR >= OFS_RULE0) &&
                          (ADDR < OFS_RULE0 + 8'(NUM_RULES));
  wire       in_preset  = (ADDR >= OFS_PRESET0) &&
                          (ADDR < OFS_PRESET0 + 8'(PRESETS));
  wire [2:0] rule_idx   = 3'(ADDR - OFS_RULE0);
  wire [3:0] preset_idx = 4'(ADDR - OFS_PRESET0);

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (ADDR == OFS_CTRL) begin
      rdata_nxt = ctrl_r;
    end else if (ADDR == OFS_JOG) begin
      rdata_nxt = {16'h0000, jog_speed_r};
    end else if (ADDR == OFS_STATUS) begin
      rdata_nxt = status_w;
    end else if (ADDR == OFS_VARS) begin
      rdata_nxt = {22'h000000, var_r};
    end else if (in_rule) begin
      rdata_nxt = rule_r[rule_idx];
    end else if (in_preset) begin
      rdata_nxt = {16'h0000, preset_r[preset_idx]};
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      rdata_r <= 32'h0000_0000;
    end else if (RD) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // read data stand for the cycle after the strobe and are zero otherwise
  assign RDATA = rdata_r;

endmodule

// >>> rtl/logic_rule_pkg.sv
// holds the constants of the logic rule action dispatcher
// assumes one clock and a synchronous active low reset
package logic_rule_pkg;

  // =====================================================================
  // sizes
  localparam int NUM_RULES  = 8;
  localparam int NUM_CONDS  = 16;
  localparam int NUM_VARS   = 10;
  localparam int SPEED_W    = 16;
  localparam int PRESETS    = 15;

  // =====================================================================
  // logical operator codes
  typedef enum logic [2:0] {
    OP_OR   = 3'h0,
    OP_AND  = 3'h1,
    OP_XOR  = 3'h2,
    OP_NOR  = 3'h3,
    OP_NAND = 3'h4,
    OP_RSVD = 3'h5
  } op_e;

  // =====================================================================
  // action codes
  localparam logic [5:0] ACT_DOUT1    = 6'h00;
  localparam logic [5:0] ACT_DOUT2    = 6'h01;
  localparam logic [5:0] ACT_RELAY1   = 6'h02;
  localparam logic [5:0] ACT_DRV_EN   = 6'h04;
  localparam logic [5:0] ACT_JOG_REV  = 6'h05;
  localparam logic [5:0] ACT_JOG_FWD  = 6'h06;
  localparam logic [5:0] ACT_STOP     = 6'h08;
  localparam logic [5:0] ACT_JOG_EN   = 6'h12;
  localparam logic [5:0] ACT_FAULT    = 6'h13;
  localparam logic [5:0] ACT_FWD_EN   = 6'h14;
  localparam logic [5:0] ACT_REV_EN   = 6'h15;
  localparam logic [5:0] ACT_ACC_GRP  = 6'h16;
  localparam logic [5:0] ACT_RESET    = 6'h17;
  localparam logic [5:0] ACT_PRESET   = 6'h18;
  localparam logic [5:0] ACT_IDX0     = 6'h19;
  localparam logic [5:0] ACT_VAR_BASE = 6'h28;

  // =====================================================================
  // register map, word offsets on the plain port
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_RULE0    = 8'h10;
  localparam logic [7:0] OFS_PRESET0  = 8'h20;
  localparam logic [7:0] OFS_JOG      = 8'h30;
  localparam logic [7:0] OFS_STATUS   = 8'h31;
  localparam logic [7:0] OFS_VARS     = 8'h32;

  // ctrl field positions
  localparam int CTRL_SRC1  = 0;
  localparam int CTRL_SRC2  = 1;
  localparam int CTRL_SRCR  = 2;
  localparam int CTRL_RUN   = 3;

  // rule word fields: cond mask [15:0], operator [18:16], action [29:24]
  localparam int RULE_OP_LSB  = 16;
  localparam int RULE_ACT_LSB = 24;

  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] RULE_RST  = 32'h3F00_0000;
  localparam logic [SPEED_W-1:0] SPEED_RST = 16'h0000;

endpackage

// >>> tb/logic_rule_dispatch_chk.sv
// holds port assertions of the logic rule dispatcher
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module logic_rule_dispatch_chk
  import logic_rule_pkg::*;
(
  input wire logic                 CLK,
  input wire logic                 NRST,
  input wire logic [7:0]           ADDR,
  input wire logic                 RD,
  input wire logic [31:0]          RDATA,
  input wire logic                 HW_ENABLE_IN,
  input wire logic [SPEED_W-1:0]   SPEED_CMD_IN,
  input wire logic                 DOUT1,
  input wire logic                 DOUT2,
  input wire logic                 RELAY1,
  input wire logic                 DRIVE_EN,
  input wire logic                 JOG_FWD,
  input wire logic                 JOG_REV,
  input wire logic                 STOP_REQ,
  input wire logic                 LOGIC_FAULT,
  input wire logic                 FWD_EN,
  input wire logic                 REV_EN,
  input wire logic                 ACC_GROUP2,
  input wire logic                 RESET_REQ,
  input wire logic                 PRESET_ACTIVE,
  input wire logic [SPEED_W-1:0]   SPEED_REF
);
  wire logic [11:0] lv;
  assign lv = {LOGIC_FAULT, STOP_REQ, JOG_REV, JOG_FWD, DRIVE_EN,
               ACC_GROUP2, PRESET_ACTIVE, REV_EN, FWD_EN, RELAY1,
               DOUT2, DOUT1};
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);
  // =====================================================================
  // assertions
  sequence one_pulse_s;
    RESET_REQ ##1 !RESET_REQ;
  endsequence
  rdata_idle_a: assert property (!RD |=> RDATA == 32'h0)
    else $error("read data not zero outside a read");
  status_mirror_a: assert property (RD && ADDR == OFS_STATUS |=>
    RDATA[17:6] == $past(lv) && RDATA[31:18] == 14'h0)
    else $error("status word differs from outputs");
  unmapped_zero_a: assert property (RD && ADDR == 8'h40 |=> RDATA == 32'h0)
    else $error("unmapped read not zero");
  var_width_a: assert property (RD && ADDR == OFS_VARS |=>
    RDATA[31:10] == 22'h0)
    else $error("variable word upper bits set");
  jog_exclusive_a: assert property (!(JOG_FWD && JOG_REV))
    else $error("both jog directions active");
  reset_pulse_a: assert property (RESET_REQ |-> one_pulse_s)
    else $error("reset request longer than one cycle");
  drive_hw_a: assert property (DRIVE_EN |->
    $past(HW_ENABLE_IN, 3))
    else $error("drive enabled without hardware enable");
  speed_cmd_a: assert property ($past(NRST) && !PRESET_ACTIVE &&
    !JOG_FWD && !JOG_REV |-> SPEED_REF == $past(SPEED_CMD_IN))
    else $error("speed reference not from command source");
endmodule
bind logic_rule_dispatch logic_rule_dispatch_chk i_chk (.*);

// >>> tb/logic_rule_dispatch_tb.sv
// holds the self-checking bench of the logic rule dispatcher
// assumes the checker is bound and the core model drives the speed source
`timescale 1ns/1ps
module logic_rule_dispatch_tb;
  import logic_rule_pkg::*;
  localparam logic [15:0] CMD = 16'h1234;
  logic        CLK, NRST, WR, RD, HW_ENABLE_IN;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA, d, seed;
  logic [15:0] COND_IN, SPEED_CMD_IN, SPEED_REF, m, c, pa, pb;
  logic [2:0]  op;
  logic        DOUT1, DOUT2, RELAY1, DRIVE_EN, JOG_FWD, JOG_REV, STOP_REQ;
  logic        LOGIC_FAULT, FWD_EN, REV_EN, ACC_GROUP2, RESET_REQ;
  logic        PRESET_ACTIVE, trip;
  int          n_errors, cmp_count, rc, i;
  logic [5:0]  ac[8] = '{ACT_DOUT1, ACT_DOUT2, ACT_RELAY1, ACT_STOP,
                          ACT_FAULT, ACT_FWD_EN, ACT_REV_EN, ACT_ACC_GRP};
  int          ix[8] = '{0, 1, 2, 10, 11, 3, 4, 6};
  logic [5:0]  rs[7] = '{6'h03, 6'h07, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D};
  logic [15:0] jc[4] = '{16'h2, 16'h3, 16'h5, 16'h7};
  logic [2:0]  je[4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  wire  [11:0] lv = {LOGIC_FAULT, STOP_REQ, JOG_REV, JOG_FWD, DRIVE_EN,
                     ACC_GROUP2, PRESET_ACTIVE, REV_EN, FWD_EN, RELAY1,
                     DOUT2, DOUT1};
  logic_rule_dispatch i_dut (.*);
  motion_core_model #(.CMD_SPEED(CMD), .EXT_TRIP_ON(1'b0)) i_core (
    .clk(CLK), .reset_req(RESET_REQ), .eighth_in(COND_IN[7]),
    .speed_cmd(SPEED_CMD_IN), .ext_trip(trip), .reset_cnt(rc));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // =====================================================================
  // bus tasks and expectations
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= v;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CLK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 d = RDATA;
  endtask
  task automatic rule(input int n, input logic [5:0] a, input logic [2:0] o,
                      input logic [15:0] k);
    wr(OFS_RULE0 + 8'(n), {2'h0, a, 5'h0, o, k});
  endtask
  task automatic clr;
    for (int n = 0; n < NUM_RULES; n++) rule(n, 6'h3F, 3'h0, 16'h0);
  endtask
  task automatic sc(input logic [15:0] k, input logic h);
    @(posedge CLK);
    COND_IN      <= k;
    HW_ENABLE_IN <= h;
    repeat (5) @(posedge CLK);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic ev(input logic [2:0] o, input logic [15:0] k, x);
    case (o)
      3'h0: ev = |(k & x);
      3'h1: ev = ((k & x) == k);
      3'h2: ev = ^(k & x);
      3'h3: ev = ~|(k & x);
      3'h4: ev = ((k & x) != k);
      default: ev = 1'b0;
    endcase
  endfunction
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    complete_run();
  end
  // =====================================================================
  // scenarios
  initial begin
    seed = 32'h3EE88EB3;
    {NRST, WR, RD, ADDR, WDATA, COND_IN} = '0;
    HW_ENABLE_IN = 1'b1;
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    rd(OFS_CTRL);
    chk(d, CTRL_RST);
    rd(OFS_RULE0 + 8'h7);
    chk(d, RULE_RST);
    rd(8'h40);
    chk(d, 32'h0);
    wr(OFS_CTRL, 32'h0000_000F);
    for (i = 0; i < 48; i++) begin
      op = 3'(i % 6);
      m  = 16'($random(seed));
      c  = (i % 4 == 0) ? m : 16'($random(seed));
      rule(0, ac[i % 8], op, m);
      sc(c, 1'b1);
      chk(lv[ix[i % 8]], ev(op, m, c));
    end
    chk(trip, 1'b0);
    rd(OFS_STATUS);
    wr(OFS_CTRL, 32'h0000_0008);
    rule(0, ACT_DOUT1, OP_OR, 16'h1);
    sc(16'h1, 1'b1);
    chk(DOUT1, 1'b0);
    wr(OFS_CTRL, 32'h0000_000F);
    sc(16'h1, 1'b1);
    chk(DOUT1, 1'b1);
    for (i = 0; i < 7; i++) begin
      rule(0, rs[i], OP_OR, 16'h1);
      sc(16'h1, 1'b1);
      chk(lv, 12'h080);
    end
    rule(0, ACT_DRV_EN, OP_OR, 16'h1);
    sc(16'h1, 1'b1);
    chk(DRIVE_EN, 1'b1);
    sc(16'h0, 1'b1);
    chk(DRIVE_EN, 1'b0);
    sc(16'h1, 1'b0);
    chk(DRIVE_EN, 1'b0);
    rule(0, 6'h3F, OP_OR, 16'h1);
    sc(16'h1, 1'b1);
    chk(DRIVE_EN, 1'b1);
    rule(0, ACT_JOG_EN, OP_OR, 16'h1);
    rule(1, ACT_JOG_FWD, OP_OR, 16'h2);
    rule(2, ACT_JOG_REV, OP_OR, 16'h4);
    pa = 16'($random(seed));
    wr(OFS_JOG, {16'h0, pa});
    for (i = 0; i < 4; i++) begin
      sc(jc[i], 1'b1);
      chk({JOG_FWD, JOG_REV, STOP_REQ}, je[i]);
    end
    sc(16'h3, 1'b1);
    chk(SPEED_REF, pa);
    clr();
    rule(0, ACT_RESET, OP_OR, 16'h1);
    sc(16'h0, 1'b1);
    i = rc;
    sc(16'h1, 1'b1);
    sc(16'h1, 1'b1);
    chk(rc - i, 1);
    sc(16'h0, 1'b1);
    sc(16'h1, 1'b1);
    chk(rc - i, 2);
    pa = 16'($random(seed));
    pb = 16'($random(seed));
    wr(OFS_PRESET0, {16'h0, pa});
    wr(OFS_PRESET0 + 8'h1, {16'h0, pb});
    rule(0, ACT_PRESET, OP_OR, 16'h1);
    rule(1, ACT_IDX0, OP_OR, 16'h2);
    sc(16'h2, 1'b1);
    chk({PRESET_ACTIVE, SPEED_REF}, {1'b0, CMD});
    sc(16'h1, 1'b1);
    chk({PRESET_ACTIVE, SPEED_REF}, {1'b1, pa});
    sc(16'h3, 1'b1);
    chk({PRESET_ACTIVE, SPEED_REF}, {1'b1, pb});
    clr();
    for (i = 0; i < NUM_VARS; i++) begin
      rule(0, ACT_VAR_BASE + 6'(i), OP_AND, 16'h1);
      sc(16'h1, 1'b1);
      rd(OFS_VARS);
      chk(d, 32'h1 << i);
    end
    complete_run();
  end
endmodule

// >>> tb/motion_core_model.sv
// holds a model of the motion and speed control core
// assumes it sits on the action outputs of the dispatcher
`timescale 1ns/1ps
module motion_core_model #(
  parameter logic [15:0] CMD_SPEED   = 16'h1234,
  parameter logic        EXT_TRIP_ON = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        reset_req,
  input  wire logic        eighth_in,
  output logic      [15:0] speed_cmd,
  output logic             ext_trip,
  output int               reset_cnt
);
  // external trip stays off while the eighth input feeds a fault rule
  assign ext_trip = EXT_TRIP_ON & eighth_in;
  // speed command source feeding the dispatcher
  assign speed_cmd = CMD_SPEED;
  initial reset_cnt = 0;
  // each one-cycle request is one reset
  always @(posedge clk) begin
    if (reset_req === 1'b1) begin
      reset_cnt <= reset_cnt + 1;
    end
  end
endmodule
